// ### board_model.sv
`timescale 1ns/1ps
`default_nettype none
// board devices: drive every pin the device leaves undriven
module board_model (
	input wire gpio_pkg::gp_pad_t         gp_pad_i,
	input wire gpio_pkg::mf_pad_t         mf_pad_i,
	input wire logic [gpio_pkg::GP_N-1:0] gp_drive_i,
	input wire logic [gpio_pkg::MF_N-1:0] mf_drive_i,
	output logic     [gpio_pkg::GP_N-1:0] gp_pin_o,
	output logic     [gpio_pkg::MF_N-1:0] mf_pin_o
);
	// the device wins where its enable is high
	assign gp_pin_o = (gp_pad_i.oe & gp_pad_i.data) | (~gp_pad_i.oe & gp_drive_i);
	assign mf_pin_o = (mf_pad_i.oe & mf_pad_i.data) | (~mf_pad_i.oe & mf_drive_i);
endmodule // board_model
`default_nettype wire

// ### gpio_pkg.sv
package gpio_pkg;

	// port counts
	localparam int GP_N = 7;                             // general purpose ports
	localparam int MF_N = 32;                            // multi-function ports

	// clock and debounce timing
	localparam int CLK_KHZ          = 250000;            // system clock rate in kHz
	localparam int DEB_TICK_MS      = 8;                 // debounce sample period in ms
	localparam int DEB_TICK_CYCLES  = DEB_TICK_MS * CLK_KHZ; // cycles per debounce sample
	localparam int DEB_SAMPLES      = 3;                 // matching samples to accept a level
	localparam int DEB_WINDOW_MIN_MS = 16;               // shortest accepted stable time
	localparam int DEB_WINDOW_MAX_MS = 24;               // longest accepted stable time

	// register word offsets (byte addresses)
	localparam logic [7:0] GP_DIRECTION_OFS   = 8'h00;  // gp direction, 1 = output
	localparam logic [7:0] GP_DATA_OUT_OFS    = 8'h04;  // gp output data
	localparam logic [7:0] GP_DATA_IN_OFS     = 8'h08;  // gp selected input level, read only
	localparam logic [7:0] GP_DEBOUNCE_OFS    = 8'h0c;  // gp debounce select, 1 = debounced
	localparam logic [7:0] GP_POWER_DOWN_OFS  = 8'h10;  // gp power-down enable
	localparam logic [7:0] MF_DIRECTION_OFS   = 8'h14;  // mf direction, 1 = output
	localparam logic [7:0] MF_DATA_OUT_OFS    = 8'h18;  // mf output data
	localparam logic [7:0] MF_DATA_IN_OFS     = 8'h1c;  // mf pin level, read only
	localparam logic [7:0] MF_SELECT_OFS      = 8'h20;  // mf function select, 1 = plain port
	localparam logic [7:0] MF_POWER_DOWN_OFS  = 8'h24;  // mf power-down enable

	// reset values
	localparam logic [GP_N-1:0] GP_DIRECTION_RST  = 7'h00;
	localparam logic [GP_N-1:0] GP_DATA_OUT_RST   = 7'h00;
	localparam logic [GP_N-1:0] GP_DEBOUNCE_RST   = 7'h00;
	localparam logic [GP_N-1:0] GP_POWER_DOWN_RST = 7'h00;
	localparam logic [MF_N-1:0] MF_DIRECTION_RST  = 32'h00000000;
	localparam logic [MF_N-1:0] MF_DATA_OUT_RST   = 32'h00000000;
	localparam logic [MF_N-1:0] MF_SELECT_RST     = 32'hf20f0fff;
	localparam logic [MF_N-1:0] MF_POWER_DOWN_RST = 32'h00000000;

	// peripheral outputs wired to the mux with no power-down gating
	localparam logic [MF_N-1:0] MF_UNGATED_MASK   = 32'he300d000;

	// pad drive for a group of pins
	typedef struct packed {
		logic [GP_N-1:0] data;                           // value driven when enabled
		logic [GP_N-1:0] oe;                             // output enable, high drives
		logic [GP_N-1:0] pull_down;                      // pull-down enable
	} gp_pad_t;

	typedef struct packed {
		logic [MF_N-1:0] data;
		logic [MF_N-1:0] oe;
		logic [MF_N-1:0] pull_down;
	} mf_pad_t;

	// edge events toward the interrupt module
	typedef struct packed {
		logic [GP_N-1:0] rise;
		logic [GP_N-1:0] fall;
	} gp_evt_t;

	typedef struct packed {
		logic [MF_N-1:0] rise;
		logic [MF_N-1:0] fall;
	} mf_evt_t;

endpackage

// ### gpio_ports.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RULE1] seven general ports, each direction set separately
// [RULE2] general port rising and falling edge events
// [RULE3] debounce accepts level stable 16-24 ms
// [RULE4] per-port select: debounced or raw input
// [RULE5] selected input feeds data-in and edge detector
// [RULE6] general data-in reads real pin level
// [RULE7] general output from data reg, enable from direction
// [RULE8] general power-down bit: drive low, pull-down; the code turns the output enable off with data low instead of driving
// [RULE9] power-down when supply-good or core-on low
// [RULE10] thirty-two multi-function ports, input/output/peripheral
// [RULE11] multi-function plain ports give both edge events
// [RULE12] multi-function input undebounced to reg, edge, peripheral
// [RULE13] multi-function data-in reads real pin level
// [RULE14] multi-function output muxed register or peripheral
// [RULE15] multi-function enable muxed direction or peripheral
// [RULE16] multi-function power-down bit: gate low, pull-down
// [RULE17] function selects reset to fixed pattern
// [RULE18] eight peripheral outputs bypass power-down gating
// [RULE19] edge events compare input with previous sample
// [RULE20] debounce on slow ticks; inputs synchronised first
// [RULE21] two lowest ports carry debug test signals
module gpio_ports #(
	parameter int DEB_TICK_CYCLES = gpio_pkg::DEB_TICK_CYCLES   // cycles per debounce sample
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// classic wishbone slave
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [7:0]                 wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	// supply state
	input  wire logic                       io_supply_good_i,
	input  wire logic                       core_power_on_i,
	// general purpose pins
	input  wire logic [gpio_pkg::GP_N-1:0]  gp_pin_i,
	output gpio_pkg::gp_pad_t               gp_pad_o,
	output gpio_pkg::gp_evt_t               gp_evt_o,
	// multi-function pins
	input  wire logic [gpio_pkg::MF_N-1:0]  multi_function_pin_i,
	output gpio_pkg::mf_pad_t               mf_pad_o,
	output gpio_pkg::mf_evt_t               mf_evt_o,
	// alternate peripheral side
	input  wire logic [gpio_pkg::MF_N-1:0]  mf_periph_data_i,
	input  wire logic [gpio_pkg::MF_N-1:0]  mf_periph_oe_i,
	output logic      [gpio_pkg::MF_N-1:0]  mf_periph_in_o
);

	// local short names for the port counts
	localparam int GN = gpio_pkg::GP_N;
	localparam int MN = gpio_pkg::MF_N;
	localparam int TW = $clog2(DEB_TICK_CYCLES + 1);       // divider width

	// software registers
	logic [GN-1:0] gp_direction;                           // 1 = output
	logic [GN-1:0] gp_data_out;                            // output data
	logic [GN-1:0] gp_debounce_select;                     // 1 = debounced input
	logic [GN-1:0] gp_power_down;                          // power-down enable
	logic [MN-1:0] mf_direction;                           // 1 = output
	logic [MN-1:0] mf_data_out;                            // output data
	logic [MN-1:0] mf_function_select;                     // 1 = plain port, 0 = peripheral
	logic [MN-1:0] mf_power_down;                          // power-down enable

	// input path state
	logic [GN-1:0] gp_sync_a;                              // first synchroniser stage
	logic [GN-1:0] gp_sync_b;                              // second synchroniser stage
	logic [GN-1:0] gp_debounced;                           // debouncer output
	logic [GN-1:0] gp_selected;                            // raw or debounced
	logic [GN-1:0] gp_prev;                                // previous selected sample
	logic [MN-1:0] mf_sync_a;                              // first synchroniser stage
	logic [MN-1:0] mf_sync_b;                              // second synchroniser stage
	logic [MN-1:0] mf_prev;                                // previous pin sample

	// debounce timing
	logic [TW-1:0] tick_count;                             // divider counter
	logic          deb_tick;                               // one-cycle sample enable

	// output path
	logic          device_power_down;                      // supply lost
	logic [MN-1:0] periph_data_gated;                      // peripheral data after gating
	logic [MN-1:0] periph_oe_gated;                        // peripheral enable after gating
	logic [MN-1:0] next_mf_data;                           // mux result
	logic [MN-1:0] next_mf_oe;                             // mux result

	// bus
	logic          bus_req;                                // new request this cycle
	logic [31:0]   next_rdata;                             // decoded read value

	// merge written bytes into an old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
		input logic [3:0] sel);
		logic [31:0] res;
		// start from the old value, then overlay enabled lanes
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = wdat[8*b +: 8];
			end
		end
		return res;
	endfunction

	// ---- bus slave ----

	// a request is taken once; ack is dropped the cycle after it rose
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// acknowledge every access one cycle after strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			// high for exactly one cycle per taken request
			wb_ack_o <= bus_req;
		end
	end

	// register writes, byte lanes honoured
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// every register back to its reset value
			gp_direction       <= gpio_pkg::GP_DIRECTION_RST;
			gp_data_out        <= gpio_pkg::GP_DATA_OUT_RST;
			gp_debounce_select <= gpio_pkg::GP_DEBOUNCE_RST;
			gp_power_down      <= gpio_pkg::GP_POWER_DOWN_RST;
			mf_direction       <= gpio_pkg::MF_DIRECTION_RST;
			mf_data_out        <= gpio_pkg::MF_DATA_OUT_RST;
			mf_function_select <= gpio_pkg::MF_SELECT_RST; // RULE17
			mf_power_down      <= gpio_pkg::MF_POWER_DOWN_RST;
		end else if (bus_req && wb_we_i) begin
			// word select; each register keeps unwritten byte lanes
			case (wb_adr_i)
				gpio_pkg::GP_DIRECTION_OFS: begin
					gp_direction <= GN'(merge(32'(gp_direction), wb_dat_i, wb_sel_i)); // RULE1
				end
				gpio_pkg::GP_DATA_OUT_OFS: begin
					gp_data_out <= GN'(merge(32'(gp_data_out), wb_dat_i, wb_sel_i));
				end
				gpio_pkg::GP_DEBOUNCE_OFS: begin
					gp_debounce_select <= GN'(merge(32'(gp_debounce_select), wb_dat_i, wb_sel_i));
				end
				gpio_pkg::GP_POWER_DOWN_OFS: begin
					gp_power_down <= GN'(merge(32'(gp_power_down), wb_dat_i, wb_sel_i));
				end
				gpio_pkg::MF_DIRECTION_OFS: begin
					mf_direction <= merge(mf_direction, wb_dat_i, wb_sel_i); // RULE10
				end
				gpio_pkg::MF_DATA_OUT_OFS: begin
					mf_data_out <= merge(mf_data_out, wb_dat_i, wb_sel_i);
				end
				gpio_pkg::MF_SELECT_OFS: begin
					mf_function_select <= merge(mf_function_select, wb_dat_i, wb_sel_i);
				end
				gpio_pkg::MF_POWER_DOWN_OFS: begin
					mf_power_down <= merge(mf_power_down, wb_dat_i, wb_sel_i);
				end
				// read-only and unmapped words ignore writes
				default: begin
				end
			endcase
		end
	end

	// read decode; unmapped words read zero
	always_comb begin
		// gp words zero-extended; upper bits read as zero
		case (wb_adr_i)
			gpio_pkg::GP_DIRECTION_OFS:  next_rdata = 32'(gp_direction);
			gpio_pkg::GP_DATA_OUT_OFS:   next_rdata = 32'(gp_data_out);
			gpio_pkg::GP_DATA_IN_OFS:    next_rdata = 32'(gp_selected);  // RULE6
			gpio_pkg::GP_DEBOUNCE_OFS:   next_rdata = 32'(gp_debounce_select);
			gpio_pkg::GP_POWER_DOWN_OFS: next_rdata = 32'(gp_power_down);
			gpio_pkg::MF_DIRECTION_OFS:  next_rdata = mf_direction;
			gpio_pkg::MF_DATA_OUT_OFS:   next_rdata = mf_data_out;
			gpio_pkg::MF_DATA_IN_OFS:    next_rdata = mf_sync_b;         // RULE13
			gpio_pkg::MF_SELECT_OFS:     next_rdata = mf_function_select;
			gpio_pkg::MF_POWER_DOWN_OFS: next_rdata = mf_power_down;
			default:                     next_rdata = 32'h00000000;
		endcase
	end

	// read data captured with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (bus_req) begin
			// writes return zero so stale data never looks valid
			wb_dat_o <= wb_we_i ? 32'h00000000 : next_rdata;
		end
	end

	// ---- input synchronisers ----

	// two stages per pin; the pad level is read back in either direction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gp_sync_a <= '0;
			gp_sync_b <= '0;
			mf_sync_a <= '0;
			mf_sync_b <= '0;
		end else begin
			// first stage only feeds the second stage
			gp_sync_a <= gp_pin_i;                         // RULE20
			gp_sync_b <= gp_sync_a;
			// multi-function pins use the same two-stage path
			mf_sync_a <= multi_function_pin_i;             // RULE12
			mf_sync_b <= mf_sync_a;
		end
	end

	// ---- debounce sample clock ----

	// divider gives one enable pulse per sample period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_count <= '0;
			deb_tick   <= 1'b0;
		end else if (tick_count == TW'(DEB_TICK_CYCLES - 1)) begin
			tick_count <= '0;
			deb_tick   <= 1'b1;                            // RULE20
		end else begin
			// count toward the next sample
			tick_count <= tick_count + TW'(1);
			deb_tick   <= 1'b0;
		end
	end

	// ---- per general port debounce and select ----

	// one debouncer per general port
	genvar g;
	generate
		for (g = 0; g < GN; g++) begin : gen_gp
			logic [1:0] match_count;                       // consecutive differing samples

			// a new level must be seen on three ticks in a row: 16 to 24 ms
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					match_count     <= 2'h0;
					gp_debounced[g] <= 1'b0;
				end else if (deb_tick) begin
					if (gp_sync_b[g] == gp_debounced[g]) begin
						match_count <= 2'h0;               // glitch or no change
					end else if (match_count == 2'(gpio_pkg::DEB_SAMPLES - 1)) begin
						match_count     <= 2'h0;
						// stable long enough: take the new level
						gp_debounced[g] <= gp_sync_b[g];   // RULE3
					end else begin
						// one more sample of the new level
						match_count <= match_count + 2'h1;
					end
				end
			end

			// raw path skips the debouncer entirely
			assign gp_selected[g] = gp_debounce_select[g] ? gp_debounced[g] : gp_sync_b[g]; // RULE4
		end
	endgenerate

	// ---- edge events ----

	// previous samples of the gp selected inputs and the mf pin levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gp_prev <= '0;
			mf_prev <= '0;
		end else begin
			// one-cycle-old copies for the edge compare
			gp_prev <= gp_selected;                        // RULE5
			mf_prev <= mf_sync_b;
		end
	end

	// one-cycle pulses on each difference; mf events only in plain port use
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// no events while in reset
			gp_evt_o <= '0;
			mf_evt_o <= '0;
		end else begin
			// general ports always report both edges
			gp_evt_o.rise <= gp_selected & ~gp_prev;       // RULE2 RULE19
			gp_evt_o.fall <= ~gp_selected & gp_prev;       // RULE2 RULE19
			// multi-function events masked while a peripheral owns the pin
			mf_evt_o.rise <= mf_sync_b & ~mf_prev & mf_function_select;  // RULE11 RULE19
			mf_evt_o.fall <= ~mf_sync_b & mf_prev & mf_function_select;  // RULE11 RULE19
		end
	end

	// ---- peripheral input ----

	// pin level to the owning peripheral, port 1:0 feed test logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// peripherals see low during reset
			mf_periph_in_o <= '0;
		end else begin
			// same settled level the data-in word shows
			mf_periph_in_o <= mf_sync_b;                   // RULE12 RULE21
		end
	end

	// ---- output path ----

	// supply loss on either rail powers down the pads whose power-down bit is set
	assign device_power_down = ~io_supply_good_i | ~core_power_on_i; // RULE9

	// most peripheral drives are killed in power-down, eight pass straight
	assign periph_data_gated = mf_periph_data_i &
		(gpio_pkg::MF_UNGATED_MASK | {MN{~device_power_down}}); // RULE18
	assign periph_oe_gated   = mf_periph_oe_i &
		(gpio_pkg::MF_UNGATED_MASK | {MN{~device_power_down}}); // RULE18

	// function select mux: 1 = port registers, 0 = peripheral
	always_comb begin
		// per pin, select one source for data and enable
		for (int m = 0; m < MN; m++) begin
			next_mf_data[m] = mf_function_select[m] ? mf_data_out[m]  : periph_data_gated[m]; // RULE14
			next_mf_oe[m]   = mf_function_select[m] ? mf_direction[m] : periph_oe_gated[m];   // RULE15
		end
	end

	// general pads; power-down bit forces low with pull-down
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gp_pad_o <= '0;
		end else begin
			for (int i = 0; i < GN; i++) begin
				// power-down wins over the port registers
				if (gp_power_down[i] && device_power_down) begin
					gp_pad_o.data[i]      <= 1'b0;         // RULE8
					gp_pad_o.oe[i]        <= 1'b0;
					gp_pad_o.pull_down[i] <= 1'b1;
				end else begin
					// normal drive from data and direction registers
					gp_pad_o.data[i]      <= gp_data_out[i];  // RULE7
					gp_pad_o.oe[i]        <= gp_direction[i]; // RULE7 RULE1
					gp_pad_o.pull_down[i] <= 1'b0;
				end
			end
		end
	end

	// multi-function pads; power-down bit overrides the mux
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mf_pad_o <= '0;
		end else begin
			for (int i = 0; i < MN; i++) begin
				// power-down wins over both mux sources
				if (mf_power_down[i] && device_power_down) begin
					mf_pad_o.data[i]      <= 1'b0;         // RULE16
					mf_pad_o.oe[i]        <= 1'b0;
					mf_pad_o.pull_down[i] <= 1'b1;
				end else begin
					// normal drive from the function select mux
					mf_pad_o.data[i]      <= next_mf_data[i];
					mf_pad_o.oe[i]        <= next_mf_oe[i];
					mf_pad_o.pull_down[i] <= 1'b0;
				end
			end
		end
	end

endmodule // gpio_ports
`default_nettype wire

// ### gpio_ports_properties.sv
`timescale 1ns/1ps
`default_nettype none
// watches bus answers, pad power-down forcing, edge events and peripheral input
module gpio_ports_properties #(
	parameter int DEB_TICK_CYCLES = gpio_pkg::DEB_TICK_CYCLES // cycles per debounce sample
) (
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_we_i,
	input wire logic [31:0]               wb_dat_o,
	input wire logic                      wb_ack_o,
	input wire logic                      io_supply_good_i,
	input wire logic                      core_power_on_i,
	input wire logic [gpio_pkg::MF_N-1:0] multi_function_pin_i,
	input wire gpio_pkg::gp_pad_t         gp_pad_o,
	input wire gpio_pkg::gp_evt_t         gp_evt_o,
	input wire gpio_pkg::mf_pad_t         mf_pad_o,
	input wire gpio_pkg::mf_evt_t         mf_evt_o,
	input wire logic [gpio_pkg::MF_N-1:0] mf_periph_in_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// bus answers exactly once, one cycle after a taken request
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	a_write_reads_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0) else $error("write data out");
	// power-down pads come only from a low supply and never drive
	a_gp_pd_cause: assert property (|gp_pad_o.pull_down |-> $past(!io_supply_good_i || !core_power_on_i))
		else $error("gp pull-down without power-down");
	a_mf_pd_cause: assert property (|mf_pad_o.pull_down |-> $past(!io_supply_good_i || !core_power_on_i))
		else $error("mf pull-down without power-down");
	a_pd_forces_low: assert property (((gp_pad_o.oe | gp_pad_o.data) & gp_pad_o.pull_down) == 7'h00 &&
		((mf_pad_o.oe | mf_pad_o.data) & mf_pad_o.pull_down) == 32'h0) else $error("pad driven in power-down");
	// mf events three edges after the matching pin change
	a_mf_rise_cause: assert property ((mf_evt_o.rise & ~($past(multi_function_pin_i, 3) &
		~$past(multi_function_pin_i, 4))) == 32'h0) else $error("mf rise without rising pin");
	a_mf_fall_cause: assert property ((mf_evt_o.fall & ~(~$past(multi_function_pin_i, 3) &
		$past(multi_function_pin_i, 4))) == 32'h0) else $error("mf fall without falling pin");
	a_gp_evt_pulse: assert property (((gp_evt_o.rise & $past(gp_evt_o.rise)) |
		(gp_evt_o.fall & $past(gp_evt_o.fall))) == 7'h00) else $error("gp event longer than a pulse");
	// peripheral sees the settled pin level
	a_periph_in_sync: assert property ($stable(multi_function_pin_i) [*4] |->
		mf_periph_in_o[31:2] == multi_function_pin_i[31:2]) else $error("peripheral input stale");
	c_write: cover property (wb_ack_o && $past(wb_we_i));
	c_gp_rise: cover property (|gp_evt_o.rise);
	c_mf_pd: cover property (|mf_pad_o.pull_down);
endmodule // gpio_ports_properties
bind gpio_ports gpio_ports_properties #(.DEB_TICK_CYCLES(DEB_TICK_CYCLES)) i_gpio_ports_properties (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .io_supply_good_i(io_supply_good_i),
	.core_power_on_i(core_power_on_i), .multi_function_pin_i(multi_function_pin_i), .gp_pad_o(gp_pad_o),
	.gp_evt_o(gp_evt_o), .mf_pad_o(mf_pad_o), .mf_evt_o(mf_evt_o), .mf_periph_in_o(mf_periph_in_o));
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i, rst_i, cyc, stb, we, ack, iogood, coreon;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, rdat, board_mf, pdat, poe, mfpin, pin_in;
	logic [6:0] board_gp, gppin;
	gpio_pkg::gp_pad_t gp_pad;
	gpio_pkg::gp_evt_t gp_evt;
	gpio_pkg::mf_pad_t mf_pad;
	gpio_pkg::mf_evt_t mf_evt;
	int mismatches, total_checks, gp_r, gp_f, mf_r, mf_f;
	gpio_ports #(.DEB_TICK_CYCLES(8)) i_gpio_ports (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.io_supply_good_i(iogood), .core_power_on_i(coreon), .gp_pin_i(gppin), .gp_pad_o(gp_pad),
		.gp_evt_o(gp_evt), .multi_function_pin_i(mfpin), .mf_pad_o(mf_pad), .mf_evt_o(mf_evt),
		.mf_periph_data_i(pdat), .mf_periph_oe_i(poe), .mf_periph_in_o(pin_in));
	board_model i_board_model (.gp_pad_i(gp_pad), .mf_pad_i(mf_pad), .gp_drive_i(board_gp),
		.mf_drive_i(board_mf), .gp_pin_o(gppin), .mf_pin_o(mfpin));
	// 250 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// event pulse counters
	always @(posedge clk_i) begin
		gp_r += $countones(gp_evt.rise);
		gp_f += $countones(gp_evt.fall);
		mf_r += $countones(mf_evt.rise);
		mf_f += $countones(mf_evt.fall);
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic wishbone cycle, entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) chk(32'h1, 32'h0);
		r = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge clk_i);
	endtask
	// watchdog
	initial begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		$display("mismatch at %0t: run hung", $time);
		wrap_up();
	end
	initial begin
		logic [31:0] r, exp_tab [11];
		exp_tab = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hf20f0fff, 32'h0, 32'h0};
		rst_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hf; dat = 0; iogood = 1; coreon = 1;
		board_gp = 0; board_mf = 0; pdat = 0; poe = 0; gp_r = 0; gp_f = 0; mf_r = 0; mf_f = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// reset values of every word and an unmapped one
		for (int i = 0; i < 11; i++) begin
			xfer(1'b0, 8'(i * 4), 32'h0, r);
			chk(r, exp_tab[i]);
		end
		xfer(1'b1, 8'h28, 32'hffffffff, r);
		xfer(1'b0, 8'h28, 32'h0, r);
		chk(r, 32'h0);
		// gp direction, output data and pin readback
		board_gp <= 7'h0f;
		xfer(1'b1, gpio_pkg::GP_DIRECTION_OFS, 32'h55, r);
		xfer(1'b1, gpio_pkg::GP_DATA_OUT_OFS, 32'h33, r);
		repeat (2) @(posedge clk_i);
		xfer(1'b0, gpio_pkg::GP_DATA_IN_OFS, 32'h0, r);
		chk(r, 32'h1b);
		chk(32'(gp_pad.oe), 32'h55);
		chk(32'(gp_pad.data & gp_pad.oe), 32'h11);
		// mf as plain ports
		board_mf <= 32'h12345678;
		xfer(1'b1, gpio_pkg::MF_SELECT_OFS, 32'hffffffff, r);
		xfer(1'b1, gpio_pkg::MF_DIRECTION_OFS, 32'hf0f0f0f0, r);
		xfer(1'b1, gpio_pkg::MF_DATA_OUT_OFS, 32'haaaaaaaa, r);
		repeat (2) @(posedge clk_i);
		xfer(1'b0, gpio_pkg::MF_DATA_IN_OFS, 32'h0, r);
		chk(r, (32'haaaaaaaa & 32'hf0f0f0f0) | (32'h12345678 & 32'h0f0f0f0f));
		chk(mf_pad.oe, 32'hf0f0f0f0);
		// mf carrying peripheral data and direction
		pdat <= 32'h5a5a5a5a;
		poe <= 32'h0ff00ff0;
		xfer(1'b1, gpio_pkg::MF_SELECT_OFS, 32'h0, r);
		repeat (4) @(posedge clk_i);
		chk(mf_pad.oe, 32'h0ff00ff0);
		chk(mf_pad.data & mf_pad.oe, 32'h0a500a50);
		chk(pin_in & 32'hfffffffc, 32'h1a545a58);
		// edge events, mf bit 27 handed to its peripheral
		board_gp <= 7'h00; board_mf <= 32'h0; poe <= 32'h0;
		xfer(1'b1, gpio_pkg::GP_DIRECTION_OFS, 32'h0, r);
		xfer(1'b1, gpio_pkg::MF_DIRECTION_OFS, 32'h0, r);
		xfer(1'b1, gpio_pkg::MF_SELECT_OFS, 32'hf7ffffff, r);
		repeat (6) @(posedge clk_i);
		gp_r = 0; gp_f = 0; mf_r = 0; mf_f = 0;
		board_gp <= 7'h7f; board_mf <= 32'hffffffff;
		repeat (8) @(posedge clk_i);
		chk(32'(gp_r), 32'd7);
		chk(32'(mf_r), 32'd31);
		board_gp <= 7'h00; board_mf <= 32'h0;
		repeat (8) @(posedge clk_i);
		chk(32'(gp_f), 32'd7);
		chk(32'(mf_f), 32'd31);
		// debounced bit 1 lags, raw bit 2 passes at once
		xfer(1'b1, gpio_pkg::GP_DEBOUNCE_OFS, 32'h02, r);
		repeat (30) @(posedge clk_i);
		gp_r = 0;
		board_gp <= 7'h06;
		repeat (10) @(posedge clk_i);
		xfer(1'b0, gpio_pkg::GP_DATA_IN_OFS, 32'h0, r);
		chk(r, 32'h04);
		repeat (20) @(posedge clk_i);
		xfer(1'b0, gpio_pkg::GP_DATA_IN_OFS, 32'h0, r);
		chk(r, 32'h06);
		chk(32'(gp_r), 32'd2);
		// power-down from either supply signal
		xfer(1'b1, gpio_pkg::GP_POWER_DOWN_OFS, 32'h7f, r);
		xfer(1'b1, gpio_pkg::MF_POWER_DOWN_OFS, 32'hffffffff, r);
		for (int m = 0; m < 2; m++) begin
			iogood <= m[0]; coreon <= !m[0];
			repeat (3) @(posedge clk_i);
			chk(32'(gp_pad.pull_down), 32'h7f);
			chk(mf_pad.pull_down, 32'hffffffff);
			chk(32'(gp_pad.oe | gp_pad.data) | mf_pad.oe | mf_pad.data, 32'h0);
		end
		iogood <= 1'b1; coreon <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(mf_pad.pull_down, 32'h0);
		// ungated peripheral outputs survive power-down
		xfer(1'b1, gpio_pkg::MF_POWER_DOWN_OFS, 32'h0, r);
		xfer(1'b1, gpio_pkg::MF_SELECT_OFS, 32'h0, r);
		pdat <= 32'hffffffff; poe <= 32'hffffffff; iogood <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(mf_pad.data & mf_pad.oe, 32'he300d000);
		wrap_up();
	end
endmodule // tb
`default_nettype wire
